// ===== cwd_pkg.sv
package cwd_pkg;

    // Register addresses on the special function register bus
    localparam logic [7:0] ADDR_CONTROL_FLAGS  = 8'hD8;
    localparam logic [7:0] ADDR_MODE_CONFIG    = 8'hD9;
    localparam logic [7:0] ADDR_MODULE4_MODE   = 8'hDE;
    localparam logic [7:0] ADDR_COUNTER_LOW    = 8'hF9;
    localparam logic [7:0] ADDR_COUNTER_HIGH   = 8'hFA;
    localparam logic [7:0] ADDR_WD_OFFSET      = 8'hFD;
    localparam logic [7:0] ADDR_WD_COMPARE_HI  = 8'hFE;

    // Control register fields
    localparam int CTL_OVERFLOW_BIT = 7;
    localparam int CTL_RUN_BIT      = 6;
    localparam int CTL_MOD4_BIT     = 4;
    localparam int CTL_FLAGS_MSB    = 4;

    // Mode register fields
    localparam int MD_IDLE_BIT      = 7;
    localparam int MD_WD_ENABLE_BIT = 6;
    localparam int MD_WD_LOCK_BIT   = 5;
    localparam int MD_TB_MSB        = 3;
    localparam int MD_TB_LSB        = 1;
    localparam int MD_OVF_IRQ_BIT   = 0;

    // Module mode register fields used here
    localparam int M4_MATCH_BIT     = 3;
    localparam int M4_IRQ_EN_BIT    = 0;

    // Reset values
    localparam logic [7:0] RST_CONTROL_FLAGS = 8'h00;
    localparam logic [7:0] RST_MODE_CONFIG   = 8'h40;
    localparam logic [7:0] RST_BYTE          = 8'h00;

    // Counter limits
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [7:0]  LOW_MAX   = 8'hFF;

    // Prescaler divisors, terminal counts
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [1:0] DIV4_LAST  = 2'h3;
    localparam logic [2:0] DIV8_LAST  = 3'h7;

    // Timebase codes
    typedef enum logic [2:0] {
        CWD_TB_SYS_DIV12 = 3'h0,
        CWD_TB_SYS_DIV4  = 3'h1,
        CWD_TB_TIMER0    = 3'h2,
        CWD_TB_EXT_FALL  = 3'h3,
        CWD_TB_SYS       = 3'h4,
        CWD_TB_OSC_DIV8  = 3'h5,
        CWD_TB_RSVD6     = 3'h6,
        CWD_TB_RSVD7     = 3'h7
    } cwd_timebase_e;

    // One bus access
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } cwd_sfr_req_s;

endpackage : cwd_pkg

// ===== cwd_sync.sv
`timescale 1ns/10ps
module cwd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // Two flops; first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : cwd_sync

// ===== cwd_timebase.sv
`timescale 1ns/10ps
module cwd_timebase
    import cwd_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          reset_n,
    input  cwd_timebase_e      select,
    input  wire logic          timer0_overflow,
    input  wire logic          eci_level,
    input  wire logic          osc_level,
    output logic               tick
);

    logic [3:0] div12;
    logic [1:0] div4;
    logic [2:0] div8;
    logic       eci_prev;
    logic       osc_prev;

    wire        tick_div12 = (div12 == DIV12_LAST);
    wire        tick_div4  = (div4 == DIV4_LAST);
    wire        eci_fall   = eci_prev & ~eci_level;
    wire        osc_rise   = ~osc_prev & osc_level;
    wire        tick_osc8  = osc_rise & (div8 == DIV8_LAST);

    // Prescalers and edge history
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            div12    <= '0;
            div4     <= '0;
            div8     <= '0;
            eci_prev <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            div12    <= tick_div12 ? 4'h0 : div12 + 4'h1;
            div4     <= div4 + 2'h1;
            div8     <= osc_rise ? div8 + 3'h1 : div8;
            eci_prev <= eci_level;
            osc_prev <= osc_level;
        end
    end

    // Source select; reserved codes never tick
    assign tick = (select == CWD_TB_SYS_DIV12) ? tick_div12 :
                  (select == CWD_TB_SYS_DIV4)  ? tick_div4  :
                  (select == CWD_TB_TIMER0)    ? timer0_overflow :
                  (select == CWD_TB_EXT_FALL)  ? eci_fall   :
                  (select == CWD_TB_SYS)       ? 1'b1       :
                  (select == CWD_TB_OSC_DIV8)  ? tick_osc8  :
                  1'b0;

endmodule : cwd_timebase

// ===== cwd_watchdog.sv
// How it works
// - Reset when low byte overflows, compare equals high byte, watchdog on.
// - Writing one to module-4 flag while watchdog on forces reset.
// - Timebase and idle-suspend frozen while watchdog enabled.
// - Enable bit or lock bit turns watchdog on using module 4.
// - Lock holds watchdog on until reset; else clearing enable disables.
// - After reset watchdog on, divide-by-12, low and offset zero.
// - Counter wrap sets overflow flag; sticky until software clears it.
// - Run bit stops the counter at zero, runs it at one.
// - Module flags set by hardware, request interrupt, sticky until cleared.
// - Unused control bit 5, mode bit 4 read zero, ignore writes.
// - Idle-suspend bit halts the counter array while processor idle.
// - Three-bit timebase field selects one of six sources.
// - External oscillator divided by 8 synchronised before use.
// - Overflow interrupt enable masks or passes overflow request.
// - Overflow interrupt enable writes ignored while enable bit is one.
// - Compare high write while watchdog on reloads counter high plus offset.
// - Watchdog on forces counter run, blocks counter and module-4 mode writes.
// - Timeout equals 256 times offset plus 256 minus low byte.
`timescale 1ns/10ps
module cwd_watchdog
    import cwd_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          reset_n,
    input  cwd_sfr_req_s       sfr_req,
    input  wire logic          cpu_idle,
    input  wire logic          timer0_overflow,
    input  wire logic          eci_in,
    input  wire logic          ext_osc_in,
    input  wire logic [3:0]    module_match_event,
    input  wire logic [3:0]    module_irq_enable,
    output logic [7:0]         sfr_rdata,
    output logic               counter_array_irq,
    output logic               watchdog_reset
);

    // Stored state
    logic [7:0]  counter_low_byte;
    logic [7:0]  counter_high_byte;
    logic [7:0]  watchdog_offset_byte;
    logic [7:0]  watchdog_compare_high;
    logic [7:0]  module4_mode_register;
    logic        counter_overflow_flag;
    logic        counter_run_bit;
    logic [4:0]  module_match_flags;
    logic        idle_suspend_bit;
    logic        watchdog_enable_bit;
    logic        watchdog_lock_bit;
    cwd_timebase_e timebase_select;
    logic        overflow_irq_enable;
    logic [1:0]  pins_sync;
    logic        tb_tick;

    // Register decode
    wire wr_ctl  = sfr_req.wr & (sfr_req.addr == ADDR_CONTROL_FLAGS);
    wire wr_md   = sfr_req.wr & (sfr_req.addr == ADDR_MODE_CONFIG);
    wire wr_m4   = sfr_req.wr & (sfr_req.addr == ADDR_MODULE4_MODE);
    wire wr_low  = sfr_req.wr & (sfr_req.addr == ADDR_COUNTER_LOW);
    wire wr_high = sfr_req.wr & (sfr_req.addr == ADDR_COUNTER_HIGH);
    wire wr_off  = sfr_req.wr & (sfr_req.addr == ADDR_WD_OFFSET);
    wire wr_cmp  = sfr_req.wr & (sfr_req.addr == ADDR_WD_COMPARE_HI);
    wire [7:0] wd = sfr_req.wdata;

    // Watchdog enable state
    wire wd_on = watchdog_enable_bit | watchdog_lock_bit;

    // Counter run decision
    wire suspended = idle_suspend_bit & cpu_idle;
    wire running   = (counter_run_bit | wd_on) & ~suspended;
    wire advance   = running & tb_tick;
    wire [15:0] count      = {counter_high_byte, counter_low_byte};
    wire [15:0] count_next = count + 16'h0001;
    wire low_ovf   = advance & (counter_low_byte == LOW_MAX);
    wire wrap      = advance & (count == COUNT_MAX);

    // Watchdog trip sources
    wire wd_match  = wd_on & low_ovf
                   & (watchdog_compare_high == counter_high_byte);
    wire wd_force  = wd_on & wr_ctl & wd[CTL_MOD4_BIT];

    // Module 4 as plain compare when watchdog off
    wire m4_match  = ~wd_on & advance
                   & module4_mode_register[M4_MATCH_BIT]
                   & (count == {watchdog_compare_high,
                                watchdog_offset_byte});
    wire [4:0] flag_set = {m4_match, module_match_event};
    wire [4:0] flag_en  = {module4_mode_register[M4_IRQ_EN_BIT],
                           module_irq_enable};

    // Counter writes allowed only with watchdog off
    wire cnt_wr_low  = wr_low & ~wd_on;
    wire cnt_wr_high = wr_high & ~wd_on;

    // Mode write gating
    wire md_write    = wr_md & ~watchdog_enable_bit;
    wire md_freeze   = wd_on;

    // Compare high reload value
    wire [7:0] cmp_reload = counter_high_byte + watchdog_offset_byte;

    // Read data
    wire [7:0] rd_ctl = {counter_overflow_flag, counter_run_bit, 1'b0,
                         module_match_flags};
    wire [7:0] rd_md  = {idle_suspend_bit, watchdog_enable_bit,
                         watchdog_lock_bit, 1'b0, timebase_select,
                         overflow_irq_enable};
    wire [7:0] rd_mux =
        (sfr_req.addr == ADDR_CONTROL_FLAGS) ? rd_ctl :
        (sfr_req.addr == ADDR_MODE_CONFIG)   ? rd_md :
        (sfr_req.addr == ADDR_MODULE4_MODE)  ? module4_mode_register :
        (sfr_req.addr == ADDR_COUNTER_LOW)   ? counter_low_byte :
        (sfr_req.addr == ADDR_COUNTER_HIGH)  ? counter_high_byte :
        (sfr_req.addr == ADDR_WD_OFFSET)     ? watchdog_offset_byte :
        (sfr_req.addr == ADDR_WD_COMPARE_HI) ? watchdog_compare_high :
        8'h00;

    // Interrupt request
    wire irq_next = (counter_overflow_flag & overflow_irq_enable)
                  | |(module_match_flags & flag_en);

    // Next flag values; hardware set wins over software clear
    wire next_overflow = wrap |
        (wr_ctl ? wd[CTL_OVERFLOW_BIT] : counter_overflow_flag);
    wire [4:0] next_flags = flag_set |
        (wr_ctl ? wd[CTL_FLAGS_MSB:0] : module_match_flags);

    // Pin synchronisers
    cwd_sync #(
        .WIDTH    (2)
    ) u_pin_sync (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .async_in ({ext_osc_in, eci_in}),
        .sync_out (pins_sync)
    );

    // Counter timebase
    cwd_timebase u_timebase (
        .mclk            (mclk),
        .reset_n         (reset_n),
        .select          (timebase_select),
        .timer0_overflow (timer0_overflow),
        .eci_level       (pins_sync[0]),
        .osc_level       (pins_sync[1]),
        .tick            (tb_tick)
    );

    // Counter bytes
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            counter_low_byte  <= RST_BYTE;
            counter_high_byte <= RST_BYTE;
        end else begin
            if (cnt_wr_low) begin
                counter_low_byte <= wd;
            end else if (advance) begin
                counter_low_byte <= count_next[7:0];
            end
            if (cnt_wr_high) begin
                counter_high_byte <= wd;
            end else if (advance) begin
                counter_high_byte <= count_next[15:8];
            end
        end
    end

    // Control register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            counter_overflow_flag <= RST_CONTROL_FLAGS[CTL_OVERFLOW_BIT];
            counter_run_bit       <= RST_CONTROL_FLAGS[CTL_RUN_BIT];
            module_match_flags    <= RST_CONTROL_FLAGS[CTL_FLAGS_MSB:0];
        end else begin
            counter_overflow_flag <= next_overflow;
            module_match_flags    <= next_flags;
            if (wr_ctl) begin
                counter_run_bit <= wd[CTL_RUN_BIT];
            end
        end
    end

    // Mode register; enable and lock stay writable so software can
    // still disable or lock the watchdog while the rest is frozen
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            idle_suspend_bit    <= RST_MODE_CONFIG[MD_IDLE_BIT];
            watchdog_enable_bit <= RST_MODE_CONFIG[MD_WD_ENABLE_BIT];
            watchdog_lock_bit   <= RST_MODE_CONFIG[MD_WD_LOCK_BIT];
            timebase_select     <= cwd_timebase_e'(
                RST_MODE_CONFIG[MD_TB_MSB:MD_TB_LSB]);
            overflow_irq_enable <= RST_MODE_CONFIG[MD_OVF_IRQ_BIT];
        end else begin
            if (wr_md) begin
                watchdog_enable_bit <= wd[MD_WD_ENABLE_BIT];
                watchdog_lock_bit   <= watchdog_lock_bit
                                     | wd[MD_WD_LOCK_BIT];
            end
            if (md_write) begin
                overflow_irq_enable <= wd[MD_OVF_IRQ_BIT];
            end
            if (md_write && !md_freeze) begin
                idle_suspend_bit <= wd[MD_IDLE_BIT];
                timebase_select  <= cwd_timebase_e'(
                    wd[MD_TB_MSB:MD_TB_LSB]);
            end
        end
    end

    // Module 4 registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            watchdog_offset_byte  <= RST_BYTE;
            watchdog_compare_high <= RST_BYTE;
            module4_mode_register <= RST_BYTE;
        end else begin
            if (wr_off) begin
                watchdog_offset_byte <= wd;
            end
            if (wr_cmp) begin
                watchdog_compare_high <= wd_on ? cmp_reload : wd;
            end
            if (wr_m4 && !wd_on) begin
                module4_mode_register <= wd;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sfr_rdata         <= 8'h00;
            counter_array_irq <= 1'b0;
            watchdog_reset    <= 1'b0;
        end else begin
            sfr_rdata         <= rd_mux;
            counter_array_irq <= irq_next;
            watchdog_reset    <= wd_match | wd_force;
        end
    end

endmodule : cwd_watchdog

// ===== cwd_watchdog_assertions.sv
`timescale 1ns/10ps
module cwd_watchdog_chk
    import cwd_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  cwd_sfr_req_s    sfr_req,
    input  wire logic       cpu_idle,
    input  wire logic       timer0_overflow,
    input  wire logic       eci_in,
    input  wire logic       ext_osc_in,
    input  wire logic [3:0] module_match_event,
    input  wire logic [3:0] module_irq_enable,
    input  wire logic [7:0] sfr_rdata,
    input  wire logic       counter_array_irq,
    input  wire logic       watchdog_reset
);
    logic [7:0]  md;
    logic [11:0] cnt;
    logic        m4_ie, quiet, seen;
    wire         wd_on = md[MD_WD_ENABLE_BIT] | md[MD_WD_LOCK_BIT];
    wire         wr_md = sfr_req.wr && sfr_req.addr == ADDR_MODE_CONFIG;
    wire         rd_ct = !sfr_req.wr && sfr_req.addr == ADDR_CONTROL_FLAGS;
    wire         wr_ct = sfr_req.wr && sfr_req.addr == ADDR_CONTROL_FLAGS;

    // Mode register shadow and cycles since a write-free reset
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            md    <= RST_MODE_CONFIG;
            m4_ie <= 1'h0;
            quiet <= 1'h1;
            seen  <= 1'h0;
            cnt   <= 12'h000;
        end else begin
            if (wr_md)
                md <= wd_on ? {md[7], sfr_req.wdata[6],
                      md[5] | sfr_req.wdata[5], 1'h0, md[3:1],
                      md[6] ? md[0] : sfr_req.wdata[0]}
                      : sfr_req.wdata & 8'hEF;
            if (sfr_req.wr && sfr_req.addr == ADDR_MODULE4_MODE && !wd_on)
                m4_ie <= sfr_req.wdata[M4_IRQ_EN_BIT];
            quiet <= quiet & !sfr_req.wr;
            seen  <= seen | (watchdog_reset & quiet);
            if (cnt != 12'hFFF)
                cnt <= cnt + 12'h001;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_force_reset: assert property (wr_ct && wd_on
        && sfr_req.wdata[CTL_MOD4_BIT] |=> watchdog_reset)
        else $error("forced watchdog reset missing");
    a_off_no_reset: assert property (!wd_on |=> !watchdog_reset)
        else $error("watchdog reset while disabled");
    a_mode_read: assert property (!sfr_req.wr &&
        sfr_req.addr == ADDR_MODE_CONFIG |=> sfr_rdata == $past(md))
        else $error("mode register readback wrong");
    a_ctl_unused_zero: assert property (rd_ct |=> !sfr_rdata[5])
        else $error("control bit 5 not zero");
    a_flag_irq: assert property ((module_match_event
        & module_irq_enable) != 4'h0 ##1 !wr_ct &&
        (module_irq_enable & $past(module_match_event)) != 4'h0
        |=> counter_array_irq)
        else $error("flag interrupt missing");
    a_irq_masked: assert property (module_irq_enable == 4'h0 && !m4_ie
        && !md[MD_OVF_IRQ_BIT] |=> !counter_array_irq)
        else $error("interrupt with all enables off");
    a_reset_out: assert property ($rose(reset_n) |-> sfr_rdata == 8'h00
        && !watchdog_reset && !counter_array_irq)
        else $error("outputs not cleared by reset");
    a_timeout_early: assert property (watchdog_reset && quiet
        |-> cnt >= 12'hBEA)
        else $error("default timeout too early");
    a_timeout_late: assert property (quiet && cnt == 12'hC12 |-> seen)
        else $error("default timeout missing");
endmodule : cwd_watchdog_chk

bind cwd_watchdog cwd_watchdog_chk u_chk (.mclk(mclk), .reset_n(reset_n),
    .sfr_req(sfr_req), .cpu_idle(cpu_idle),
    .timer0_overflow(timer0_overflow), .eci_in(eci_in),
    .ext_osc_in(ext_osc_in), .module_match_event(module_match_event),
    .module_irq_enable(module_irq_enable), .sfr_rdata(sfr_rdata),
    .counter_array_irq(counter_array_irq),
    .watchdog_reset(watchdog_reset));

// ===== tb.sv
`timescale 1ns/10ps
module tb;
    import cwd_pkg::*;
    logic         mclk, reset_n, cpu_idle, irq, wd_rst;
    logic         external_count_input, osc, t0_ovf;
    cwd_sfr_req_s sfr_req;
    logic [3:0]   match_ev, irq_en;
    logic [7:0]   rdata, v;
    int           err_total, n_tests;

    cwd_watchdog dut (.mclk(mclk), .reset_n(reset_n), .sfr_req(sfr_req),
        .cpu_idle(cpu_idle), .timer0_overflow(t0_ovf), .eci_in(external_count_input),
        .ext_osc_in(osc), .module_match_event(match_ev),
        .module_irq_enable(irq_en), .sfr_rdata(rdata),
        .counter_array_irq(irq), .watchdog_reset(wd_rst));

    always #50 mclk = ~mclk;

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Bus cycles: drive after falling edge, one rising edge per write, two per read
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_req = '{addr: a, wr: 1'h1, wdata: d};
        @(negedge mclk);
        sfr_req.wr = 1'h0;
    endtask : wr

    task rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        sfr_req.addr = a;
        repeat (2) @(negedge mclk);
        v = rdata;
        chk(nm, e, v);
    endtask : rdchk

    task do_reset;
        reset_n = 1'h0;
        repeat (20) @(negedge mclk);
        reset_n = 1'h1;
    endtask : do_reset

    task wait_rst(input string nm, input int lo, input int hi);
        int n;
        n = 0;
        while (wd_rst !== 1'h1 && n < hi + 5) begin
            @(negedge mclk);
            n++;
        end
        chk(nm, 8'h01, {7'h00, n >= lo && n <= hi});
        @(negedge mclk);
    endtask : wait_rst

    task t_default;
        do_reset();
        wait_rst("default timeout", 3050, 3090);
        $display("t_default done");
    endtask : t_default

    task t_regs;
        do_reset();
        rdchk("mode rst", ADDR_MODE_CONFIG, RST_MODE_CONFIG);
        rdchk("ctl rst", ADDR_CONTROL_FLAGS, RST_CONTROL_FLAGS);
        rdchk("unmapped", 8'h00, 8'h00);
        wr(ADDR_MODE_CONFIG, 8'hDF);
        rdchk("mode frozen", ADDR_MODE_CONFIG, 8'h40);
        wr(ADDR_MODE_CONFIG, 8'h00);
        rdchk("wd off", ADDR_MODE_CONFIG, 8'h00);
        wr(ADDR_MODE_CONFIG, 8'h9F);
        rdchk("mode bit4", ADDR_MODE_CONFIG, 8'h8F);
        wr(ADDR_MODE_CONFIG, 8'h89);
        wr(ADDR_COUNTER_LOW, 8'hF0);
        wr(ADDR_COUNTER_HIGH, 8'hFF);
        cpu_idle = 1'h1;
        wr(ADDR_CONTROL_FLAGS, 8'h60);
        repeat (30) @(negedge mclk);
        rdchk("idle hold", ADDR_COUNTER_LOW, 8'hF0);
        cpu_idle = 1'h0;
        repeat (20) @(negedge mclk);
        chk("ovf irq", 8'h01, {7'h00, irq});
        rdchk("ctl ovf", ADDR_CONTROL_FLAGS, 8'hC0);
        rdchk("carry", ADDR_COUNTER_HIGH, 8'h00);
        wr(ADDR_CONTROL_FLAGS, 8'h00);
        repeat (2) @(negedge mclk);
        chk("irq clear", 8'h00, {7'h00, irq});
        rdchk("ctl clear", ADDR_CONTROL_FLAGS, 8'h00);
        wr(ADDR_COUNTER_LOW, 8'h5A);
        repeat (20) @(negedge mclk);
        rdchk("stopped", ADDR_COUNTER_LOW, 8'h5A);
        irq_en = 4'h2;
        match_ev = 4'h2;
        @(negedge mclk);
        match_ev = 4'h0;
        repeat (3) @(negedge mclk);
        chk("flag irq", 8'h01, {7'h00, irq});
        rdchk("flag set", ADDR_CONTROL_FLAGS, 8'h02);
        irq_en = 4'h0;
        $display("t_regs done");
    endtask : t_regs

    task t_watchdog;
        do_reset();
        wr(ADDR_MODE_CONFIG, 8'h00);
        wr(ADDR_COUNTER_HIGH, 8'h10);
        wr(ADDR_WD_OFFSET, 8'h02);
        wr(ADDR_MODE_CONFIG, 8'h48);
        wr(ADDR_COUNTER_HIGH, 8'h55);
        rdchk("high locked", ADDR_COUNTER_HIGH, 8'h10);
        wr(ADDR_WD_COMPARE_HI, 8'hAA);
        wait_rst("offset timeout", 745, 770);
        rdchk("reload", ADDR_WD_COMPARE_HI, 8'h12);
        wr(ADDR_CONTROL_FLAGS, 8'h10);
        chk("forced", 8'h01, {7'h00, wd_rst});
        $display("t_watchdog done");
    endtask : t_watchdog

    task t_lock;
        do_reset();
        wr(ADDR_MODE_CONFIG, 8'h00);
        wr(ADDR_MODE_CONFIG, 8'h20);
        wr(ADDR_MODE_CONFIG, 8'h00);
        rdchk("lock held", ADDR_MODE_CONFIG, 8'h20);
        wr(ADDR_CONTROL_FLAGS, 8'h10);
        chk("lock force", 8'h01, {7'h00, wd_rst});
        $display("t_lock done");
    endtask : t_lock

    // Timebase sources other than the system clock
    task t_sources;
        do_reset();
        wr(ADDR_MODE_CONFIG, 8'h00);
        wr(ADDR_MODE_CONFIG, 8'h06);
        wr(ADDR_CONTROL_FLAGS, 8'h40);
        repeat (10) begin
            repeat (2) @(negedge mclk);
            external_count_input = 1'h0;
            repeat (2) @(negedge mclk);
            external_count_input = 1'h1;
        end
        repeat (5) @(negedge mclk);
        rdchk("eci count", ADDR_COUNTER_LOW, 8'h0A);
        wr(ADDR_MODE_CONFIG, 8'h04);
        repeat (7) begin
            t0_ovf = 1'h1;
            @(negedge mclk);
            t0_ovf = 1'h0;
            repeat (2) @(negedge mclk);
        end
        rdchk("timer0 count", ADDR_COUNTER_LOW, 8'h11);
        wr(ADDR_MODE_CONFIG, 8'h0A);
        repeat (32) begin
            @(negedge mclk);
            osc = ~osc;
        end
        repeat (6) @(negedge mclk);
        rdchk("osc count", ADDR_COUNTER_LOW, 8'h13);
        $display("t_sources done");
    endtask : t_sources

    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        {mclk, reset_n, cpu_idle, match_ev, irq_en} = '0;
        sfr_req = '0;
        {t0_ovf, osc} = '0;
        external_count_input = 1'h1;
        err_total = 0;
        n_tests = 0;
        t_default();
        t_regs();
        t_watchdog();
        t_lock();
        t_sources();
        stop_test();
    end

    // Hang guard, about twice the expected run
    initial begin
        #1_000_000;
        err_total++;
        stop_test();
    end
endmodule : tb
